// file: verilog/alcg_pkg.sv
// Purpose: Shared constants of the automatic level control block
// Assumes: Levels are attenuation below full scale in 0.01 dB units
// Notes:   Gains are signed codes in 0.75 dB units
package alcg_pkg;
   // Register indices; the byte address is four times the index
   localparam logic [7:0] IDX_CFG = 8'h11;
   localparam logic [7:0] IDX_STS = 8'h12;
   localparam logic [7:0] IDX_GATE = 8'h18;
   localparam logic [7:0] IDX_IRQ_ST = 8'h19;
   localparam logic [7:0] IDX_IRQ_CLR = 8'h1a;
   localparam logic [7:0] IDX_IRQ_EN = 8'h1b;
   // Configuration register fields
   localparam int CFG_MON = 10;
   localparam int CFG_RANGE = 9;
   localparam int CFG_EN_L = 8;
   localparam int CFG_EN_R = 7;
   localparam int CFG_MAX_LSB = 4;
   localparam int CFG_LVL_LSB = 0;
   localparam logic [15:0] CFG_RESET = 16'h007b;
   localparam logic [15:0] CFG_WMASK = 16'h07ff;
   // Status and control register fields
   localparam int STS_LOCK = 15;
   localparam int STS_ABOVE = 14;
   localparam int STS_SAT = 13;
   localparam int STS_PK = 12;
   localparam int STS_GATE = 11;
   localparam int CTL_ZC = 7;
   localparam int CTL_MIN_LSB = 4;
   localparam int CTL_HOLD_LSB = 0;
   localparam logic [7:0] CTL_RESET = 8'h00;
   localparam logic [4:0] GATE_RESET = 5'h00;
   // Interrupt bits
   localparam int IRQ_LOCK = 0;
   localparam int IRQ_PK = 1;
   localparam int IRQ_SAT = 2;
   localparam int IRQ_GATE = 3;
   localparam int IRQ_W = 4;
   // Level figures, 0.01 dB attenuation
   localparam int LW = 14;
   localparam logic [LW-1:0] LVL_BOT_LO = 14'h0b22;
   localparam logic [LW-1:0] LVL_BOT_HI = 14'h08ca;
   localparam logic [LW-1:0] LVL_TOP_HI = 14'h0096;
   localparam logic [LW-1:0] LVL_STEP = 14'h0096;
   localparam logic [LW-1:0] LOCK_TOL = 14'h004b;
   localparam logic [LW-1:0] PK_ATTEN = 14'h0074;
   localparam logic [LW-1:0] GATE_BOT = 14'h1de2;
   // Gain figures, 0.75 dB units
   localparam int GW = 8;
   localparam logic signed [GW-1:0] MAX_BASE = -8'sd24;
   localparam logic signed [GW-1:0] MIN_BASE = -8'sd31;
   localparam logic signed [GW-1:0] GAIN_MOVE = 8'sd2;
   // Hold time base
   localparam int CLK_PERIOD_NS = 50;
   localparam int HOLD_BASE_NS = 2670000;
   localparam int HOLD_BASE_CYC = (HOLD_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// file: verilog/alcg_chan.sv
// Purpose: One channel of the level controller
// Assumes: level_valid marks a fresh level measurement
// Notes:   Gain out is the controller gain only when enabled and active
`timescale 1ns/1ps
`default_nettype none
module alcg_chan
   import alcg_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Settings
   input wire logic enable,
   input wire logic active,
   input wire logic zc_mode,
   input wire logic [LW-1:0] target,
   input wire logic signed [GW-1:0] max_gain,
   input wire logic signed [GW-1:0] min_gain,
   input wire logic [31:0] hold_cyc,
   input wire logic signed [GW-1:0] volume,
   // Signal events
   input wire logic level_valid,
   input wire logic [LW-1:0] level,
   input wire logic zero_cross,
   // Results
   output logic signed [GW-1:0] gain,
   output logic locked,
   output logic above,
   output logic saturated
);
   typedef struct packed {
      logic signed [GW-1:0] ctrl;
      logic signed [GW-1:0] pend;
      logic pend_vld;
      logic [31:0] hold;
      logic below;
      logic locked;
      logic above;
      logic sat;
      logic signed [GW-1:0] out;
   } alcg_chan_t;

   alcg_chan_t s_r, s_nxt;
   logic [LW:0] lv, tg;
   logic lock_now, louder, quieter;
   logic signed [GW:0] want;

   assign lv = {1'b0, level};
   assign tg = {1'b0, target};
   assign lock_now = (lv + {1'b0, LOCK_TOL} >= tg) && (lv <= tg + {1'b0, LOCK_TOL});
   assign louder = (lv + {1'b0, LOCK_TOL}) < tg;
   assign quieter = lv > (tg + {1'b0, LOCK_TOL});

   always_comb begin
      s_nxt = s_r;
      want = {s_r.ctrl[GW-1], s_r.ctrl};
      if (!enable) begin
         s_nxt = '0;
         s_nxt.ctrl = volume;
      end else begin
         if (s_r.below && s_r.hold < hold_cyc) begin
            s_nxt.hold = s_r.hold + 32'h1;
         end
         if (zc_mode && s_r.pend_vld && zero_cross) begin
            s_nxt.ctrl = s_r.pend;
            s_nxt.pend_vld = 1'b0;
         end
         if (!zc_mode) begin
            s_nxt.pend_vld = 1'b0;
         end
         if (level_valid) begin
            s_nxt.locked = lock_now;
            s_nxt.above = louder;
            s_nxt.below = quieter;
            s_nxt.sat = quieter && (s_r.ctrl >= max_gain);
            if (louder) begin
               want = {s_r.ctrl[GW-1], s_r.ctrl} - {GAIN_MOVE[GW-1], GAIN_MOVE};
               s_nxt.hold = '0;
            end else if (quieter) begin
               if (s_r.hold >= hold_cyc) begin
                  want = {s_r.ctrl[GW-1], s_r.ctrl} + {GAIN_MOVE[GW-1], GAIN_MOVE};
               end
            end else begin
               s_nxt.hold = '0;
            end
            // Concatenations are unsigned, so sign the limits before comparing
            if (want > $signed({max_gain[GW-1], max_gain})) begin
               want = {max_gain[GW-1], max_gain};
            end
            if (want < $signed({min_gain[GW-1], min_gain})) begin
               want = {min_gain[GW-1], min_gain};
            end
            if (want[GW-1:0] != s_r.ctrl) begin
               if (zc_mode) begin
                  s_nxt.pend = want[GW-1:0];
                  s_nxt.pend_vld = 1'b1;
               end else begin
                  s_nxt.ctrl = want[GW-1:0];
               end
            end
         end
      end
      s_nxt.out = (enable && active) ? s_nxt.ctrl : volume;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign gain = s_r.out;
   assign locked = s_r.locked;
   assign above = s_r.above;
   assign saturated = s_r.sat;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   a_lock_flag: assert property (enable && level_valid && lock_now |=> locked)
      else $error("lock flag not set at target level");
   a_above_flag: assert property (enable && level_valid && !lock_now |=> above == $past(louder))
      else $error("threshold flag wrong while unlocked");
   a_sat_flag: assert property (enable && level_valid && quieter && s_r.ctrl >= max_gain
      |=> saturated)
      else $error("saturation flag missing at gain ceiling");
   a_zc_wait: assert property (enable && zc_mode && !zero_cross ##1 enable && zc_mode
      |-> $stable(s_r.ctrl))
      else $error("gain moved without zero cross");
   a_hold_wait: assert property (enable && level_valid && quieter && s_r.hold < hold_cyc
      && !(zc_mode && s_r.pend_vld && zero_cross) |=> s_r.ctrl <= $past(s_r.ctrl))
      else $error("gain ramped up during hold");
endmodule
`default_nettype wire

// file: verilog/alcg_top.sv
// Purpose: Automatic level control registers, status and two channels
// Assumes: AHB-Lite slave, zero wait states, single word transfers
// Notes:   Level inputs are attenuation below full scale, 0.01 dB units
`timescale 1ns/1ps
`default_nettype none
module alcg_top
   import alcg_pkg::*;
#(
   parameter int HOLD_UNIT_CYC = HOLD_BASE_CYC
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic ARST_N,
   // AHB-Lite slave
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   // Measured signal
   input wire logic LEVEL_VALID,
   input wire logic [alcg_pkg::LW-1:0] LEVEL_L,
   input wire logic [alcg_pkg::LW-1:0] LEVEL_R,
   input wire logic ZERO_CROSS_L,
   input wire logic ZERO_CROSS_R,
   // Manual volumes
   input wire logic signed [alcg_pkg::GW-1:0] LEFT_INPUT_VOLUME,
   input wire logic signed [alcg_pkg::GW-1:0] RIGHT_INPUT_VOLUME,
   // PGA gains and interrupt
   output logic signed [alcg_pkg::GW-1:0] GAIN_L,
   output logic signed [alcg_pkg::GW-1:0] GAIN_R,
   output logic IRQ
);
   import alcg_pkg::*;

   typedef struct packed {
      logic [15:0] cfg;
      logic [7:0] ctl;
      logic [4:0] gate;
      logic [IRQ_W-1:0] irq_st;
      logic [IRQ_W-1:0] irq_en;
      logic [IRQ_W-1:0] prev;
      logic pk;
      logic ng;
      logic wr_pend;
      logic [7:0] wr_idx;
      logic [31:0] rdata;
   } alcg_top_t;

   alcg_top_t s_r, s_nxt;

   // Decoded settings
   logic en_l, en_r, any_en, mon, range_hi, zc;
   logic [3:0] lvl_code, hold_code;
   logic [2:0] max_code, min_code;
   logic [LW-1:0] tgt_raw, target, gate_lvl;
   logic signed [GW-1:0] max_gain, min_gain;
   logic [31:0] hold_cyc;
   // Channel results
   logic lock_l, lock_r, above_l, above_r, sat_l, sat_r;
   logic f_lock, f_above, f_sat;
   logic [IRQ_W-1:0] cur, events;
   // Bus phase decode
   logic addr_ok, mapped;
   logic [7:0] idx;

   assign en_l = s_r.cfg[CFG_EN_L];
   assign en_r = s_r.cfg[CFG_EN_R];
   assign any_en = en_l || en_r;
   assign mon = s_r.cfg[CFG_MON];
   assign range_hi = s_r.cfg[CFG_RANGE];
   assign lvl_code = s_r.cfg[CFG_LVL_LSB +: 4];
   assign max_code = s_r.cfg[CFG_MAX_LSB +: 3];
   assign zc = s_r.ctl[CTL_ZC];
   assign min_code = s_r.ctl[CTL_MIN_LSB +: 3];
   assign hold_code = s_r.ctl[CTL_HOLD_LSB +: 4];

   // Target attenuation from range and code
   assign tgt_raw = (range_hi ? LVL_BOT_HI : LVL_BOT_LO) - {10'h000, lvl_code} * LVL_STEP;
   assign target = (range_hi && tgt_raw < LVL_TOP_HI) ? LVL_TOP_HI : tgt_raw;

   // Gain limits, 6 dB per code is eight 0.75 dB units
   assign max_gain = MAX_BASE + $signed({2'b00, max_code, 3'b000});
   assign min_gain = MIN_BASE + $signed({2'b00, min_code, 3'b000});

   // Hold doubles per code from the base unit; code zero holds not at all
   assign hold_cyc = (hold_code == 4'h0) ? 32'h0
      : (32'(HOLD_UNIT_CYC) << (hold_code - 4'h1));

   assign gate_lvl = GATE_BOT - {9'h000, s_r.gate} * LVL_STEP;

   alcg_chan u_left (
      .clk(CLK),
      .arst_n(ARST_N),
      .enable(en_l),
      .active(!mon),
      .zc_mode(zc),
      .target(target),
      .max_gain(max_gain),
      .min_gain(min_gain),
      .hold_cyc(hold_cyc),
      .volume(LEFT_INPUT_VOLUME),
      .level_valid(LEVEL_VALID),
      .level(LEVEL_L),
      .zero_cross(ZERO_CROSS_L),
      .gain(GAIN_L),
      .locked(lock_l),
      .above(above_l),
      .saturated(sat_l)
   );

   alcg_chan u_right (
      .clk(CLK),
      .arst_n(ARST_N),
      .enable(en_r),
      .active(!mon),
      .zc_mode(zc),
      .target(target),
      .max_gain(max_gain),
      .min_gain(min_gain),
      .hold_cyc(hold_cyc),
      .volume(RIGHT_INPUT_VOLUME),
      .level_valid(LEVEL_VALID),
      .level(LEVEL_R),
      .zero_cross(ZERO_CROSS_R),
      .gain(GAIN_R),
      .locked(lock_r),
      .above(above_r),
      .saturated(sat_r)
   );

   // Locked only when every enabled channel is locked
   assign f_lock = any_en && (!en_l || lock_l) && (!en_r || lock_r);
   assign f_above = !f_lock && ((en_l && above_l) || (en_r && above_r));
   assign f_sat = (en_l && sat_l) || (en_r && sat_r);

   assign cur[IRQ_LOCK] = f_lock;
   assign cur[IRQ_PK] = s_r.pk;
   assign cur[IRQ_SAT] = f_sat;
   assign cur[IRQ_GATE] = s_r.ng;
   assign events = cur & ~s_r.prev;

   assign addr_ok = HSEL && HTRANS[1] && HREADY;
   assign idx = HADDR[9:2];
   assign mapped = (HADDR[31:10] == 22'h0) && (HADDR[1:0] == 2'b00);

   function automatic logic [31:0] read_word(input logic [7:0] i, input alcg_top_t st,
                                             input logic [IRQ_W-1:0] c);
      logic [31:0] w;
      w = 32'h0;
      unique case (i)
         IDX_CFG: w[15:0] = st.cfg;
         IDX_STS: begin
            w[STS_LOCK] = c[IRQ_LOCK];
            w[STS_ABOVE] = f_above;
            w[STS_SAT] = c[IRQ_SAT];
            w[STS_PK] = c[IRQ_PK];
            w[STS_GATE] = c[IRQ_GATE];
            w[7:0] = st.ctl;
         end
         IDX_GATE: w[4:0] = st.gate;
         IDX_IRQ_ST: w[IRQ_W-1:0] = st.irq_st;
         IDX_IRQ_EN: w[IRQ_W-1:0] = st.irq_en;
         default: w = 32'h0;
      endcase
      return w;
   endfunction

   always_comb begin
      s_nxt = s_r;
      s_nxt.prev = cur;
      // Peak and gate are judged on each fresh level
      if (!any_en) begin
         s_nxt.pk = 1'b0;
         s_nxt.ng = 1'b0;
      end else if (LEVEL_VALID) begin
         s_nxt.pk = (en_l && LEVEL_L < PK_ATTEN) || (en_r && LEVEL_R < PK_ATTEN);
         s_nxt.ng = (en_l && LEVEL_L > gate_lvl) || (en_r && LEVEL_R > gate_lvl);
      end
      // Data phase of a write
      s_nxt.wr_pend = 1'b0;
      if (s_r.wr_pend) begin
         unique case (s_r.wr_idx)
            IDX_CFG: s_nxt.cfg = HWDATA[15:0] & CFG_WMASK;
            IDX_STS: s_nxt.ctl = HWDATA[7:0];
            IDX_GATE: s_nxt.gate = HWDATA[4:0];
            IDX_IRQ_CLR: s_nxt.irq_st = s_r.irq_st & ~HWDATA[IRQ_W-1:0];
            IDX_IRQ_EN: s_nxt.irq_en = HWDATA[IRQ_W-1:0];
            default: s_nxt.wr_pend = 1'b0;
         endcase
      end
      // A new event outlives a clear in the same cycle
      s_nxt.irq_st = s_nxt.irq_st | events;
      // Address phase
      if (addr_ok) begin
         s_nxt.wr_pend = HWRITE && mapped;
         s_nxt.wr_idx = idx;
         s_nxt.rdata = (!HWRITE && mapped) ? read_word(idx, s_r, cur) : 32'h0;
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         s_r <= '0;
         s_r.cfg <= CFG_RESET;
         s_r.ctl <= CTL_RESET;
         s_r.gate <= GATE_RESET;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign HRDATA = s_r.rdata;
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;
   assign IRQ = |(s_r.irq_st & s_r.irq_en);

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!ARST_N);

   sequence s_loud_left;
      LEVEL_VALID && en_l && LEVEL_L < PK_ATTEN;
   endsequence
   sequence s_quiet_left;
      LEVEL_VALID && en_l && LEVEL_L > gate_lvl;
   endsequence

   a_peak_flag: assert property (s_loud_left |=> s_r.pk)
      else $error("peak overload flag not set");
   a_gate_flag: assert property (s_quiet_left |=> s_r.ng)
      else $error("gate closed flag not set");
   a_flags_idle: assert property (!any_en ##1 !any_en |-> !cur[IRQ_PK] && !cur[IRQ_GATE]
      && !cur[IRQ_LOCK] && !f_above)
      else $error("status flag set with no channel enabled");
   a_follow_left: assert property (!en_l |=> GAIN_L == $past(LEFT_INPUT_VOLUME))
      else $error("left gain not following left volume");
   a_follow_right: assert property (!en_r |=> GAIN_R == $past(RIGHT_INPUT_VOLUME))
      else $error("right gain not following right volume");
   a_monitor_gain: assert property (mon && en_l |=> GAIN_L == $past(LEFT_INPUT_VOLUME))
      else $error("monitor mode drove the gain");
   a_range_bottom: assert property (lvl_code == 4'h0
      |-> target == (range_hi ? LVL_BOT_HI : LVL_BOT_LO))
      else $error("target bottom wrong for range");
   a_target_top: assert property (range_hi && lvl_code[3:1] == 3'b111
      |-> target == LVL_TOP_HI)
      else $error("upper range top code wrong");
   a_event_sticks: assert property (events != '0 |=> (s_r.irq_st & $past(events)) == $past(events))
      else $error("interrupt event lost");
endmodule
`default_nettype wire

// file: tb/tb_alc_gain_control.sv
// Purpose: Self-checking bench of the level control block
// Assumes: Zero wait state bus; hold unit shortened to four clocks
// Notes:   Table rows give config and levels beside the expected flags
`timescale 1ns/1ps
`default_nettype none
module tb_alc_gain_control;
   import alcg_pkg::*;
   typedef struct {
      logic [15:0] cfg;
      logic [LW-1:0] ll;
      logic [LW-1:0] lr;
      logic [4:0] fl;
   } alcg_row_t;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic level_valid = 1'b0;
   logic [LW-1:0] level_l = 14'h0000;
   logic [LW-1:0] level_r = 14'h0000;
   logic zc_l = 1'b0;
   logic zc_r = 1'b0;
   logic signed [GW-1:0] vol_l = 8'h00;
   logic signed [GW-1:0] vol_r = 8'h00;
   logic signed [GW-1:0] gain_l;
   logic signed [GW-1:0] gain_r;
   logic irq;
   logic [31:0] rdat;
   int n_mismatch = 0;
   int n_compared = 0;
   // Flags are lock, above, saturated, peak, gate closed
   alcg_row_t rows [13] = '{
      '{16'h01f0, 14'h0b22, 14'h0b22, 5'h10},
      '{16'h01ff, 14'h0190, 14'h0190, 5'h08},
      '{16'h03fe, 14'h0096, 14'h0096, 5'h10},
      '{16'h03ff, 14'h0064, 14'h0064, 5'h12},
      '{16'h03f0, 14'h1f40, 14'h1f40, 5'h01},
      '{16'h01b5, 14'h08fc, 14'h08fc, 5'h04},
      '{16'h03f1, 14'h087f, 14'h087f, 5'h10},
      '{16'h03f1, 14'h07e8, 14'h07e8, 5'h08},
      '{16'h01ff, 14'h0032, 14'h0032, 5'h0a},
      '{16'h0170, 14'h0b22, 14'h0190, 5'h10},
      '{16'h01f0, 14'h0b22, 14'h0190, 5'h08},
      '{16'h0070, 14'h0032, 14'h0032, 5'h00},
      '{16'h05f0, 14'h0b22, 14'h0b22, 5'h10}
   };

   alcg_top #(.HOLD_UNIT_CYC(4)) alcg_top_inst (
      .CLK(clk), .ARST_N(arst_n),
      .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
      .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
      .HRESP(hresp),
      .LEVEL_VALID(level_valid), .LEVEL_L(level_l), .LEVEL_R(level_r),
      .ZERO_CROSS_L(zc_l), .ZERO_CROSS_R(zc_r),
      .LEFT_INPUT_VOLUME(vol_l), .RIGHT_INPUT_VOLUME(vol_r),
      .GAIN_L(gain_l), .GAIN_R(gain_r), .IRQ(irq)
   );

   always #25 clk = ~clk;

   task automatic end_sim;
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   // Bounded wait for hready; a hang ends the run
   task automatic wait_rdy;
      int k;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (hreadyout !== 1'b1 && k < 64);
      if (hreadyout !== 1'b1) begin
         n_mismatch++;
         end_sim();
      end
   endtask

   task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {22'h000000, idx, 2'h0};
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      rdat = hrdata;
   endtask

   task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
      bus(1'b0, idx, 32'h0);
      chk(rdat, exp);
      chk({31'h0, hresp}, 32'h0);
   endtask

   task automatic sample(input logic [LW-1:0] l, input logic [LW-1:0] r);
      @(posedge clk);
      level_valid <= 1'b1;
      level_l <= l;
      level_r <= r;
      @(posedge clk);
      level_valid <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   task automatic zcross(input logic l, input logic r);
      @(posedge clk);
      zc_l <= l;
      zc_r <= r;
      @(posedge clk);
      zc_l <= 1'b0;
      zc_r <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   task automatic gains(input logic [7:0] el, input logic [7:0] er);
      chk({16'h0000, gain_l, gain_r}, {16'h0000, el, er});
   endtask

   task automatic irq_is(input logic e);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, {31'h0, e});
   endtask

   // Restart a channel pair from the volumes, then apply config and control
   task automatic restart(input logic [15:0] cfg, input logic [7:0] ctl);
      bus(1'b1, IDX_CFG, 32'h007f);
      bus(1'b1, IDX_STS, {24'h000000, ctl});
      bus(1'b1, IDX_CFG, {16'h0000, cfg});
   endtask

   initial begin
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      foreach (rows[i]) begin
         bus(1'b1, IDX_CFG, {16'h0000, rows[i].cfg & 16'hfe7f});
         bus(1'b1, IDX_CFG, {16'h0000, rows[i].cfg});
         sample(rows[i].ll, rows[i].lr);
         bus(1'b0, IDX_STS, 32'h0);
         chk({27'h0, rdat[15:11]}, {27'h0, rows[i].fl});
      end
      // Every flag rose during the table
      rdchk(IDX_IRQ_ST, 32'hf);
      bus(1'b1, IDX_IRQ_EN, 32'h1);
      irq_is(1'b1);
      bus(1'b1, IDX_IRQ_EN, 32'h0);
      irq_is(1'b0);
      bus(1'b1, IDX_IRQ_CLR, 32'h5);
      rdchk(IDX_IRQ_ST, 32'ha);
      bus(1'b1, IDX_IRQ_EN, 32'h2);
      irq_is(1'b1);
      bus(1'b1, IDX_IRQ_CLR, 32'hf);
      irq_is(1'b0);
      // Gate threshold raised to 30 dB attenuation
      bus(1'b1, IDX_GATE, 32'h1f);
      rdchk(IDX_GATE, 32'h1f);
      restart(16'h01f0, 8'h00);
      sample(14'h0c1c, 14'h0c1c);
      rdchk(IDX_STS, 32'h0800);
      sample(14'h0b54, 14'h0b54);
      rdchk(IDX_STS, 32'h8000);
      // Disabled channels follow the volumes
      bus(1'b1, IDX_CFG, 32'h007f);
      vol_l <= 8'h05;
      vol_r <= 8'hf9;
      repeat (3) @(posedge clk);
      gains(8'h05, 8'hf9);
      vol_l <= 8'h00;
      vol_r <= 8'h00;
      restart(16'h01ff, 8'h00);
      sample(14'h012c, 14'h012c);
      gains(8'hfe, 8'hfe);
      sample(14'h012c, 14'h012c);
      gains(8'hfc, 8'hfc);
      sample(14'h07d0, 14'h07d0);
      gains(8'hfe, 8'hfe);
      bus(1'b1, IDX_CFG, 32'h00ff);
      sample(14'h012c, 14'h012c);
      gains(8'h00, 8'hfc);
      bus(1'b1, IDX_CFG, 32'h05ff);
      sample(14'h012c, 14'h012c);
      gains(8'h00, 8'h00);
      // Floor code 3 stops the fall at -5.25 dB
      restart(16'h01ff, 8'h30);
      repeat (4) sample(14'h012c, 14'h012c);
      gains(8'hf9, 8'hf9);
      // Ceiling code 3 stops the rise at 0 dB
      vol_l <= 8'hfd;
      vol_r <= 8'hfd;
      restart(16'h01b5, 8'h30);
      sample(14'h08fc, 14'h08fc);
      gains(8'hff, 8'hff);
      sample(14'h08fc, 14'h08fc);
      gains(8'h00, 8'h00);
      // Saturation is judged on the gain held when the next level arrives
      sample(14'h08fc, 14'h08fc);
      gains(8'h00, 8'h00);
      rdchk(IDX_STS, 32'h2030);
      vol_l <= 8'h00;
      vol_r <= 8'h00;
      // Zero-cross mode holds each change until that channel crosses
      restart(16'h01ff, 8'h80);
      sample(14'h012c, 14'h012c);
      gains(8'h00, 8'h00);
      zcross(1'b1, 1'b0);
      gains(8'hfe, 8'h00);
      zcross(1'b0, 1'b1);
      gains(8'hfe, 8'hfe);
      // Hold code 2 is eight clocks here before any ramp-up
      restart(16'h01ff, 8'h02);
      sample(14'h07d0, 14'h07d0);
      gains(8'h00, 8'h00);
      repeat (12) @(posedge clk);
      sample(14'h07d0, 14'h07d0);
      gains(8'h02, 8'h02);
      // Second reset in mid-run
      bus(1'b1, IDX_IRQ_EN, 32'hf);
      @(posedge clk);
      arst_n <= 1'b0;
      vol_l <= 8'h0a;
      vol_r <= 8'h03;
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      rdchk(IDX_CFG, 32'h007b);
      gains(8'h0a, 8'h03);
      rdchk(IDX_STS, 32'h0);
      rdchk(IDX_GATE, 32'h0);
      rdchk(IDX_IRQ_EN, 32'h0);
      rdchk(IDX_IRQ_ST, 32'h0);
      bus(1'b1, 8'h10, 32'hffff);
      rdchk(8'h10, 32'h0);
      bus(1'b1, IDX_STS, 32'hffff);
      rdchk(IDX_STS, 32'h00ff);
      bus(1'b1, IDX_CFG, 32'hffffffff);
      rdchk(IDX_CFG, 32'h07ff);
      end_sim();
   end
endmodule
`default_nettype wire
